//--- sim/usb_dev_events_suspend_clk_tb_top.sv
// Testbench for the device event status and suspend clocking block
`timescale 1ns/10ps
module usb_dev_events_suspend_clk_tb_top;
    localparam int FRAME = 40;
    logic clk, arst_n, cs_n, rd_n, wr_n, a0, oe, cin, cout, sof, transfer_end_event, res, brst, wake, susp, osc, cko;
    logic [15:0] din;
    logic [15:0] dout;
    logic [13:0] ep;
    logic [31:0] rng;
    logic [31:0] v;
    logic [15:0] lo;
    logic o;
    int err_count, check_count, cyc, c;

    usb_dev_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .data_in(din),
        .data_out(dout), .data_oe(oe));
    usb_dev_events_suspend_clk #(.FRAME_CYCLES(FRAME), .SUSP_ENTRY_CYCLES(20), .WAKE_CYCLES(10)) dut (
        .clk(clk), .arst_n(arst_n), .bus_cs_n(cs_n), .bus_rd_n(rd_n), .bus_wr_n(wr_n), .bus_a0(a0),
        .bus_data_in(din), .bus_data_out(dout), .bus_data_oe(oe), .endpoint_event(ep),
        .control_in_event(cin), .control_out_event(cout), .sof_detect(sof), .dma_count_zero(transfer_end_event),
        .resume_detect(res), .bus_reset_detect(brst), .device_wake_in(wake), .suspend_out(susp),
        .oscillator_on(osc), .clock_output(cko));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Expected latched flags for one burst of pulses that always carries a frame start
    function automatic logic [31:0] exp_ev(input logic [18:0] r);
        return {8'h00, r[13:0], r[14], r[15], 4'b0001, r[16], 1'b0, r[17], r[18]};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic pulse(input logic [18:0] r);
        @(negedge clk);
        {brst, res, transfer_end_event, cout, cin, ep} = r;
        sof = 1'b1;
        @(negedge clk);
        {brst, res, transfer_end_event, cout, cin, ep, sof} = 20'h00000;
    endtask

    task automatic toggles(input int n, output int t);
        logic p;
        t = 0;
        p = cko;
        repeat (n) begin
            @(negedge clk);
            if (cko !== p) t++;
            p = cko;
        end
    endtask

    task automatic suspend_run(input logic noslow);
        int w;
        host.write_reg(usb_dev_events_pkg::CMD_WRITE_HW_CONFIG, {10'h000, noslow, 1'b1, 4'h0});
        host.write_reg(usb_dev_events_pkg::CMD_WRITE_MODE, 16'h0020);
        host.write_reg(usb_dev_events_pkg::CMD_WRITE_MODE, 16'h0000);
        repeat (12) @(negedge clk);
        chk({31'h0, susp}, 32'h0, "suspend too early");
        w = 0;
        while (susp !== 1'b1 && w < 12) begin
            @(negedge clk);
            w++;
        end
        chk({30'h0, susp, osc}, 32'h2, "suspend entry");
        @(negedge clk);
        toggles(1000, c);
        chk(32'(noslow ? c == 0 : c >= 4 && c <= 6), 32'h1, "slow clock");
        @(negedge clk);
        wake = 1'b1;
        repeat (3) @(negedge clk);
        wake = 1'b0;
        repeat (4) @(negedge clk);
        chk({31'h0, susp}, 32'h1, "wake too early");
        w = 0;
        while (susp !== 1'b0 && w < 20) begin
            @(negedge clk);
            w++;
        end
        chk({30'h0, susp, osc}, 32'h1, "wake exit");
        toggles(40, c);
        chk(32'(c >= 38 && c <= 41), 32'h1, "clock restart");
        $display("test suspend done");
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            $display("mismatch at %0t: timeout", $time);
            stop_test;
        end
    end

    initial begin
        logic [18:0] r;
        int d;
        rng = 32'd44;
        err_count = 0;
        check_count = 0;
        cyc = 0;
        arst_n = 1'b0;
        {brst, res, transfer_end_event, cout, cin, ep, sof, wake} = 21'h000000;
        repeat (12) @(negedge clk);
        chk({12'h000, dout, oe, susp, osc, cko}, 32'h2, "reset outputs");
        arst_n = 1'b1;
        host.read_events(v);
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 19'h7ffff : 19'(xs());
            pulse(r);
            host.read_events(v);
            chk(v, exp_ev(r), "event flags");
            pulse(19'h0);
            host.read_events(v);
            chk(v, 32'h10, "flags after read");
        end
        $display("test events done");
        pulse(19'h0);
        repeat (3 * FRAME + 2) @(negedge clk);
        host.read_events(v);
        chk(v, 32'hb4, "missed frames");
        pulse(19'h0);
        host.read_events(v);
        chk(v, 32'h10, "bus awake again");
        host.wr_word(1'b1, {8'h00, usb_dev_events_pkg::CMD_WRITE_MODE});
        host.rd_word(lo, o);
        chk({15'h0, o, lo}, 32'h10000, "read under other command");
        $display("test frames done");
        host.write_reg(usb_dev_events_pkg::CMD_WRITE_HW_CONFIG, 16'h0000);
        repeat (4) @(negedge clk);
        chk({31'h0, osc}, 32'h0, "oscillator off");
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 15 : int'(xs() & 32'hf);
            host.write_reg(usb_dev_events_pkg::CMD_WRITE_HW_CONFIG, 16'h0010 | 16'(d));
            repeat (40) @(negedge clk);
            toggles(96, c);
            chk(32'(c >= 96 / (d + 1) - 1 && c <= 96 / (d + 1) + 1), 32'h1, "divided clock");
        end
        $display("test divider done");
        suspend_run(1'b0);
        suspend_run(1'b1);
        stop_test;
    end
endmodule // usb_dev_events_suspend_clk_tb_top

//--- sim/usb_dev_host_model.sv
// Microprocessor model driving the shared parallel bus
`timescale 1ns/10ps
module usb_dev_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic a0,
    output logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe
);
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        a0 = 1'b1;
        data_in = 16'h0000;
    end
    // Strobe low and high four clocks each to clear the pin synchronisers
    task automatic wr_word(input logic cmd, input logic [15:0] d);
        @(negedge clk);
        cs_n = 1'b0;
        a0 = cmd;
        data_in = d;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        data_in = ~d;
    endtask
    task automatic rd_word(output logic [15:0] d, output logic oe);
        @(negedge clk);
        cs_n = 1'b0;
        a0 = 1'b0;
        rd_n = 1'b0;
        repeat (5) @(negedge clk);
        d = data_out;
        oe = data_oe;
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
    endtask
    task automatic write_reg(input logic [7:0] c, input logic [15:0] d);
        wr_word(1'b1, {8'h00, c});
        wr_word(1'b0, d);
    endtask
    // Command then both data words, never stopping after the first
    task automatic read_events(output logic [31:0] v);
        logic [15:0] lo;
        logic [15:0] hi;
        logic oe;
        wr_word(1'b1, {8'h00, usb_dev_events_pkg::CMD_READ_EVENTS});
        rd_word(lo, oe);
        rd_word(hi, oe);
        v = {hi, lo};
    endtask
endmodule // usb_dev_host_model

//--- verilog/clk_out_gen.sv
// Programmable clock output with slow suspend clock
`timescale 1ns/10ps
module clk_out_gen (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic slow_sel,
    input wire logic [3:0] divider,
    output logic clock_output
);
    logic [7:0] half_cnt_r;
    logic [7:0] half_cnt_nxt;
    logic clk_out_r;
    logic clk_out_nxt;
    logic [7:0] half_limit;

    always_comb begin
        half_cnt_nxt = half_cnt_r;
        clk_out_nxt = clk_out_r;
        half_limit = 8'h00;
        if (run) begin
            half_limit = {4'h0, divider}; // R10
        end else if (slow_sel) begin
            half_limit = 8'(usb_dev_events_pkg::SLOW_HALF_CYCLES - 1); // R14
        end
        if (run || slow_sel) begin
            if (half_cnt_r >= half_limit) begin
                half_cnt_nxt = 8'h00;
                clk_out_nxt = ~clk_out_r;
            end else begin
                half_cnt_nxt = half_cnt_r + 8'h01;
            end
        end else begin
            half_cnt_nxt = 8'h00; // R11
            clk_out_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            half_cnt_r <= 8'h00;
            clk_out_r <= 1'b0;
        end else begin
            half_cnt_r <= half_cnt_nxt;
            clk_out_r <= clk_out_nxt;
        end
    end

    assign clock_output = clk_out_r;

    AST_SLOW_HALF_PERIOD: assert property (@(posedge clk) disable iff (!arst_n) // R14
        (slow_sel && !run && $past(slow_sel) && !$past(run) && $changed(clk_out_r))
            |-> $past(half_cnt_r) == 8'(usb_dev_events_pkg::SLOW_HALF_CYCLES - 1))
        else $error("Slow clock half period wrong");

    AST_DIV_HALF_PERIOD: assert property (@(posedge clk) disable iff (!arst_n) // R10
        (run && $past(run) && $stable(divider) && $changed(clk_out_r))
            |-> $past(half_cnt_r) >= {4'h0, divider})
        else $error("Divided clock toggled early");

    AST_STOPPED_CLOCK: assert property (@(posedge clk) disable iff (!arst_n) // R11
        (!run && !slow_sel) |=> !clk_out_r)
        else $error("Clock output running while stopped");
endmodule // clk_out_gen

//--- verilog/usb_dev_events_pkg.sv
// Constants for the device event status and suspend clocking block
package usb_dev_events_pkg;
    // Command codes on the command phase
    localparam logic [7:0] CMD_READ_EVENTS = 8'hc0;
    localparam logic [7:0] CMD_WRITE_HW_CONFIG = 8'hba;
    localparam logic [7:0] CMD_WRITE_MODE = 8'hb8;
    localparam logic [7:0] CMD_NONE = 8'h00;
    // Event register layout
    localparam int EV_EP_LO = 10;
    localparam int EV_EP_HI = 23;
    localparam int EV_CTRL_IN = 9;
    localparam int EV_CTRL_OUT = 8;
    localparam int EV_BUS_STATE = 7;
    localparam int EV_PSEUDO_FRAME_TICK = 5;
    localparam int EV_SOF = 4;
    localparam int EV_EOT = 3;
    localparam int EV_SUSP = 2;
    localparam int EV_RESUME = 1;
    localparam int EV_RESET = 0;
    localparam logic [31:0] EV_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] EV_LATCH_MASK = 32'h00ff_ff3f;
    // Hardware configuration layout
    localparam int HWC_DIV_LO = 0;
    localparam int HWC_DIV_HI = 3;
    localparam int HWC_RUN = 4;
    localparam int HWC_NOSLOW = 5;
    localparam logic [15:0] HWC_MASK = 16'h003f;
    localparam logic [15:0] HWC_RESET_VAL = 16'h0013;
    // Mode register layout
    localparam int MODE_GO_SUSP = 5;
    localparam logic MODE_GO_SUSP_RESET = 1'b0;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int FRAME_US = 1000;
    localparam int FRAME_CYCLES = CLK_HZ / 1_000_000 * FRAME_US;
    localparam int SUSP_ENTRY_US = 2000;
    localparam int SUSP_ENTRY_CYCLES = CLK_HZ / 1_000_000 * SUSP_ENTRY_US;
    localparam int WAKE_NS = 500_000;
    localparam int WAKE_CYCLES = CLK_HZ / 1_000_000 * WAKE_NS / 1000;
    localparam int SLOW_CLK_HZ = 100_000;
    localparam int SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_CLK_HZ);
    localparam logic [1:0] MISSED_FRAMES_LIMIT = 2'h3;
    localparam int CNT_W = 17;
    localparam int SYNC_W = 20;
endpackage

//--- verilog/usb_dev_events_suspend_clk.sv
// Device event status register, frame timing and suspend clock control
// Functional notes
// [R1] Endpoints 14..1 flag events in bits 23..10
// [R2] Control IN bit 9, control OUT bit 8
// [R3] Bit 7 shows live bus suspend state
// [R4] Pseudo frame flag each 1 ms; 3 misses suspend
// [R5] Bit 4 set on start-of-frame
// [R6] Bit 3 set when DMA count hits zero
// [R7] Bit 2 set on awake-to-suspend change
// [R8] Bit 1 set on bus resume
// [R9] Bit 0 set on bus reset
// [R10] Clock output divided from internal reference
// [R11] Suspend stops oscillator; slow clock optional
// [R12] Config: oscillator run, divider, slow disable
// [R13] Go-suspend set then cleared; 2 ms later suspend
// [R14] Slow disable 0 keeps slow clock in suspend
// [R15] Wake pulse; suspend clears after 0.5 ms
// [R16] Host reads events by command then data
// [R17] Host always reads both event words
// [R18] Second word read clears latched flags
`timescale 1ns/10ps
module usb_dev_events_suspend_clk #(
    parameter int FRAME_CYCLES = usb_dev_events_pkg::FRAME_CYCLES,
    parameter int SUSP_ENTRY_CYCLES = usb_dev_events_pkg::SUSP_ENTRY_CYCLES,
    parameter int WAKE_CYCLES = usb_dev_events_pkg::WAKE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic bus_a0,
    input wire logic [15:0] bus_data_in,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic [13:0] endpoint_event,
    input wire logic control_in_event,
    input wire logic control_out_event,
    input wire logic sof_detect,
    input wire logic dma_count_zero,
    input wire logic resume_detect,
    input wire logic bus_reset_detect,
    input wire logic device_wake_in,
    output logic suspend_out,
    output logic oscillator_on,
    output logic clock_output
);
    typedef enum logic [1:0] {PWR_AWAKE, PWR_ENTER, PWR_SUSP, PWR_WAKE} pwr_state_t;

    // Pin synchronisers
    logic [usb_dev_events_pkg::SYNC_W-1:0] sync1_r, sync2_r, sync3_r;
    logic [2:0] wake_sync_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= {4'hf, 16'h0000};
            sync2_r <= {4'hf, 16'h0000};
            sync3_r <= {4'hf, 16'h0000};
            wake_sync_r <= 3'h0;
        end else begin
            sync1_r <= {bus_cs_n, bus_rd_n, bus_wr_n, bus_a0, bus_data_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            wake_sync_r <= {wake_sync_r[1:0], device_wake_in};
        end
    end

    logic cs_n_s, rd_n_s, wr_n_s, a0_s;
    logic cs_n_q, rd_n_q, wr_n_q, a0_q;
    logic [15:0] din_q;
    logic rd_end, wr_end, wake_rise;

    assign {cs_n_s, rd_n_s, wr_n_s, a0_s} = sync2_r[usb_dev_events_pkg::SYNC_W-1:16];
    assign {cs_n_q, rd_n_q, wr_n_q, a0_q, din_q} = sync3_r;
    assign rd_end = !cs_n_q && !rd_n_q && rd_n_s;
    assign wr_end = !cs_n_q && !wr_n_q && wr_n_s;
    assign wake_rise = wake_sync_r[1] && !wake_sync_r[2];

    // Command and register writes
    logic [7:0] cmd_r, cmd_nxt;
    logic word_idx_r, word_idx_nxt;
    logic [15:0] hwcfg_r, hwcfg_nxt;
    logic go_susp_r, go_susp_nxt;
    logic go_susp_fall, events_read_done;

    always_comb begin
        cmd_nxt = cmd_r;
        word_idx_nxt = word_idx_r;
        hwcfg_nxt = hwcfg_r;
        go_susp_nxt = go_susp_r;
        go_susp_fall = 1'b0;
        events_read_done = 1'b0;
        if (wr_end && a0_q) begin
            cmd_nxt = din_q[7:0]; // R16
            word_idx_nxt = 1'b0;
        end else if (wr_end && cmd_r == usb_dev_events_pkg::CMD_WRITE_HW_CONFIG) begin
            hwcfg_nxt = din_q & usb_dev_events_pkg::HWC_MASK; // R12
        end else if (wr_end && cmd_r == usb_dev_events_pkg::CMD_WRITE_MODE) begin
            go_susp_nxt = din_q[usb_dev_events_pkg::MODE_GO_SUSP];
            go_susp_fall = go_susp_r && !din_q[usb_dev_events_pkg::MODE_GO_SUSP]; // R13
        end else if (rd_end && !a0_q && cmd_r == usb_dev_events_pkg::CMD_READ_EVENTS) begin
            word_idx_nxt = !word_idx_r; // R17
            events_read_done = word_idx_r; // R18
            if (word_idx_r) begin
                cmd_nxt = usb_dev_events_pkg::CMD_NONE;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_r <= usb_dev_events_pkg::CMD_NONE;
            word_idx_r <= 1'b0;
            hwcfg_r <= usb_dev_events_pkg::HWC_RESET_VAL;
            go_susp_r <= usb_dev_events_pkg::MODE_GO_SUSP_RESET;
        end else begin
            cmd_r <= cmd_nxt;
            word_idx_r <= word_idx_nxt;
            hwcfg_r <= hwcfg_nxt;
            go_susp_r <= go_susp_nxt;
        end
    end

    // Frame timer and live bus state
    logic [usb_dev_events_pkg::CNT_W-1:0] frame_cnt_r, frame_cnt_nxt;
    logic [1:0] missed_r, missed_nxt;
    logic live_bus_state_r, live_bus_state_nxt;
    logic frame_expire;

    always_comb begin
        frame_cnt_nxt = frame_cnt_r + 17'h00001;
        missed_nxt = missed_r;
        live_bus_state_nxt = live_bus_state_r;
        frame_expire = 1'b0;
        if (sof_detect) begin
            frame_cnt_nxt = 17'h00000; // R5
            missed_nxt = 2'h0;
        end else if (frame_cnt_r == 17'(FRAME_CYCLES - 1)) begin
            frame_cnt_nxt = 17'h00000; // R4
            frame_expire = 1'b1;
            if (missed_r != usb_dev_events_pkg::MISSED_FRAMES_LIMIT) begin
                missed_nxt = missed_r + 2'h1;
            end
        end
        if (sof_detect || resume_detect || bus_reset_detect) begin
            live_bus_state_nxt = 1'b0; // R3
            missed_nxt = 2'h0;
        end else if (missed_nxt == usb_dev_events_pkg::MISSED_FRAMES_LIMIT) begin
            live_bus_state_nxt = 1'b1; // R4
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_cnt_r <= 17'h00000;
            missed_r <= 2'h0;
            live_bus_state_r <= 1'b0;
        end else begin
            frame_cnt_r <= frame_cnt_nxt;
            missed_r <= missed_nxt;
            live_bus_state_r <= live_bus_state_nxt;
        end
    end

    // Latched event flags; a new event wins over the read clear
    logic [31:0] ev_r, ev_nxt, ev_set, event_word;

    always_comb begin
        ev_set = 32'h0000_0000;
        ev_set[usb_dev_events_pkg::EV_EP_HI:usb_dev_events_pkg::EV_EP_LO] = endpoint_event; // R1
        ev_set[usb_dev_events_pkg::EV_CTRL_IN] = control_in_event; // R2
        ev_set[usb_dev_events_pkg::EV_CTRL_OUT] = control_out_event; // R2
        ev_set[usb_dev_events_pkg::EV_PSEUDO_FRAME_TICK] = frame_expire; // R4
        ev_set[usb_dev_events_pkg::EV_SOF] = sof_detect; // R5
        ev_set[usb_dev_events_pkg::EV_EOT] = dma_count_zero; // R6
        ev_set[usb_dev_events_pkg::EV_SUSP] = live_bus_state_nxt && !live_bus_state_r; // R7
        ev_set[usb_dev_events_pkg::EV_RESUME] = resume_detect; // R8
        ev_set[usb_dev_events_pkg::EV_RESET] = bus_reset_detect; // R9
        ev_nxt = ev_r;
        if (events_read_done) begin
            ev_nxt = 32'h0000_0000; // R18
        end
        ev_nxt = (ev_nxt | ev_set) & usb_dev_events_pkg::EV_LATCH_MASK;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ev_r <= usb_dev_events_pkg::EV_RESET_VAL;
        end else begin
            ev_r <= ev_nxt;
        end
    end

    always_comb begin
        event_word = ev_r;
        event_word[usb_dev_events_pkg::EV_BUS_STATE] = live_bus_state_r; // R3
    end

    // Read data path
    logic [15:0] dout_r, dout_nxt;

    always_comb begin
        dout_nxt = 16'h0000;
        if (cmd_r == usb_dev_events_pkg::CMD_READ_EVENTS) begin
            dout_nxt = word_idx_r ? event_word[31:16] : event_word[15:0]; // R16
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout_r <= 16'h0000;
        end else begin
            dout_r <= dout_nxt;
        end
    end

    assign bus_data_out = dout_r;
    assign bus_data_oe = !cs_n_s && !rd_n_s && !a0_s;

    // Suspend and wake sequencing
    pwr_state_t pwr_state_r, pwr_state_nxt;
    logic [usb_dev_events_pkg::CNT_W-1:0] pwr_cnt_r, pwr_cnt_nxt;

    always_comb begin
        pwr_state_nxt = pwr_state_r;
        pwr_cnt_nxt = 17'h00000;
        unique case (pwr_state_r)
            PWR_AWAKE: begin
                if (go_susp_fall) begin
                    pwr_state_nxt = PWR_ENTER; // R13
                end
            end
            PWR_ENTER: begin
                pwr_cnt_nxt = pwr_cnt_r + 17'h00001;
                if (pwr_cnt_r == 17'(SUSP_ENTRY_CYCLES - 1)) begin
                    pwr_state_nxt = PWR_SUSP; // R13
                    pwr_cnt_nxt = 17'h00000;
                end
            end
            PWR_SUSP: begin
                if (wake_rise) begin
                    pwr_state_nxt = PWR_WAKE; // R15
                end
            end
            PWR_WAKE: begin
                pwr_cnt_nxt = pwr_cnt_r + 17'h00001;
                if (pwr_cnt_r == 17'(WAKE_CYCLES - 1)) begin
                    pwr_state_nxt = PWR_AWAKE; // R15
                    pwr_cnt_nxt = 17'h00000;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwr_state_r <= PWR_AWAKE;
            pwr_cnt_r <= 17'h00000;
        end else begin
            pwr_state_r <= pwr_state_nxt;
            pwr_cnt_r <= pwr_cnt_nxt;
        end
    end

    logic suspended;

    assign suspended = pwr_state_r == PWR_SUSP || pwr_state_r == PWR_WAKE;
    assign suspend_out = suspended;
    assign oscillator_on = hwcfg_r[usb_dev_events_pkg::HWC_RUN] && !suspended; // R11

    clk_out_gen u_clk_out_gen (
        .clk(clk),
        .arst_n(arst_n),
        .run(oscillator_on),
        .slow_sel(suspended && !hwcfg_r[usb_dev_events_pkg::HWC_NOSLOW]), // R14
        .divider(hwcfg_r[usb_dev_events_pkg::HWC_DIV_HI:usb_dev_events_pkg::HWC_DIV_LO]), // R10
        .clock_output(clock_output)
    );

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_enter_done;
        pwr_state_r == PWR_ENTER && pwr_cnt_r == 17'(SUSP_ENTRY_CYCLES - 1);
    endsequence
    sequence s_wake_done;
        pwr_state_r == PWR_WAKE && pwr_cnt_r == 17'(WAKE_CYCLES - 1);
    endsequence
    sequence s_second_word_read;
        rd_end && !a0_q && cmd_r == usb_dev_events_pkg::CMD_READ_EVENTS && word_idx_r;
    endsequence

    AST_EP_FLAGS: assert property ( // R1
        (endpoint_event != 14'h0000) |=> ((ev_r[23:10] & $past(endpoint_event)) == $past(endpoint_event)))
        else $error("Endpoint event not latched");
    AST_CTRL_FLAGS: assert property ( // R2
        (control_in_event || control_out_event) |=> (ev_r[9] || !$past(control_in_event))
            && (ev_r[8] || !$past(control_out_event)))
        else $error("Control endpoint event not latched");
    AST_LIVE_SUSPEND: assert property ( // R3
        (frame_expire && missed_r == 2'h2 && !sof_detect && !resume_detect && !bus_reset_detect)
            |=> live_bus_state_r && event_word[7])
        else $error("Bus state not suspended after missed frames");
    AST_PSEUDO_FRAME_TICK_TICK: assert property ( // R4
        (frame_cnt_r == 17'(FRAME_CYCLES - 1) && !sof_detect) |=> ev_r[5] && frame_cnt_r == 17'h00000)
        else $error("Pseudo frame tick missing");
    AST_SOF_FLAG: assert property ( // R5
        sof_detect |=> ev_r[4] && frame_cnt_r == 17'h00000 && missed_r == 2'h0)
        else $error("Start-of-frame not latched");
    AST_EOT_FLAG: assert property (dma_count_zero |=> ev_r[3]) // R6
        else $error("Transfer end not latched");
    AST_SUSP_EVENT: assert property ( // R7
        $rose(live_bus_state_r) |-> ev_r[2])
        else $error("Suspend entry event not latched");
    AST_RESUME_RESET: assert property ( // R8
        (resume_detect || bus_reset_detect) |=> (ev_r[1] || !$past(resume_detect))
            && (ev_r[0] || !$past(bus_reset_detect)) && !live_bus_state_r)
        else $error("Resume or bus reset not latched");
    AST_OSC_SUSPEND: assert property (suspended |-> !oscillator_on) // R11
        else $error("Oscillator running in suspend");
    AST_ENTER_DELAY: assert property ( // R13
        $rose(suspend_out) |-> $past(pwr_state_r) == PWR_ENTER
            && $past(pwr_cnt_r) == 17'(SUSP_ENTRY_CYCLES - 1))
        else $error("Suspend entered at wrong time");
    AST_ENTER_STEP: assert property ( // R13
        s_enter_done |=> suspend_out ##1 suspend_out)
        else $error("Suspend not entered after delay");
    AST_WAKE_DELAY: assert property ( // R15
        s_wake_done |=> !suspend_out && pwr_state_r == PWR_AWAKE)
        else $error("Wake delay wrong");
    AST_READ_CLEAR: assert property ( // R18
        (s_second_word_read and (ev_set == 32'h0000_0000)) |=> (ev_r & usb_dev_events_pkg::EV_LATCH_MASK) == 32'h0)
        else $error("Flags not cleared after event read");
endmodule // usb_dev_events_suspend_clk
